/* File: hw/ccp_unit.sv */
// capture/compare/pwm unit with register port
`timescale 1ns/10ps
module ccp_unit
    import ccp_pkg::*;
#(
    parameter int PRESC_W = 10
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PLL_CLK_EN,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic [1:0] CAP_IN,
    output logic [3:0] CMP_OUT,
    output logic [3:0] CMP_OE,
    output logic PLL_REF_EN,
    output logic IRQ
);
    // elaboration check: the prescaler logic is built for ten bits only
    if (PRESC_W != 10) begin : g_bad_presc_w
        $error("prescaler width must be 10");
    end

    logic [15:0] ctrl_q, presc_rld_q, rld_q, tmr_q, capcfg_q, outcfg_q, ien_q;
    logic [15:0] cmp_q [NUM_CMP];
    logic [15:0] cap_q [NUM_CAP];
    logic [NUM_IRQ-1:0] flags_q;
    logic [PRESC_W-1:0] presc_q;
    logic [7:0] lo_shadow_q, hi_shadow_q;
    logic [3:0] pll_cnt_q;
    logic [3:0] pin_q;
    logic sym_up_q, alt_q;
    ccp_mode_e mode;
    logic unit_clock, tick, reload;
    logic [15:0] top, tmr_d;
    logic [NUM_IRQ-1:0] set_ev;

    assign mode = ccp_mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
    assign top = ctrl_q[CTRL_W8_BIT] ? 16'h00FF : 16'hFFFF;

    // pll reference: pclk / (n+1), then pll output x32 as enable pulses
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pll_cnt_q <= 4'h0;
        end else if (pll_cnt_q >= ctrl_q[CTRL_PLLDIV_LSB +: 4]) begin
            pll_cnt_q <= 4'h0;
        end else begin
            pll_cnt_q <= pll_cnt_q + 4'h1;
        end
    end
    assign PLL_REF_EN = (pll_cnt_q == 4'h0);

    // unit clock selection: pclk in basic mode, pll output in pwm modes
    assign unit_clock = (mode == MODE_BASIC) ? 1'b1 : PLL_CLK_EN;

    // prescaler: counts up from reload, one tick per overflow
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            presc_q <= RST_PRESC;
        end else if (unit_clock && ctrl_q[CTRL_RUN_BIT]) begin
            presc_q <= (&presc_q) ? presc_rld_q[PRESC_W-1:0] : presc_q + 1'b1;
        end
    end
    assign tick = unit_clock && ctrl_q[CTRL_RUN_BIT] && (&presc_q);

    // timer next value per mode
    always_comb begin
        reload = 1'b0;
        tmr_d = tmr_q;
        case (mode)
            MODE_BASIC: begin
                if (ctrl_q[CTRL_DIR_BIT]) begin // down
                    reload = (tmr_q == 16'h0000);
                    tmr_d = reload ? rld_q : tmr_q - 16'h0001;
                end else begin
                    reload = (tmr_q == top);
                    tmr_d = reload ? rld_q : tmr_q + 16'h0001;
                end
            end
            MODE_ASYM: begin
                reload = (tmr_q == 16'h0000);
                tmr_d = reload ? rld_q : tmr_q - 16'h0001;
            end
            MODE_SYM: begin
                if (sym_up_q) begin
                    tmr_d = tmr_q + 16'h0001;
                end else begin
                    reload = (tmr_q == 16'h0000);
                    tmr_d = reload ? tmr_q + 16'h0001 : tmr_q - 16'h0001;
                end
            end
            default: begin
                tmr_d = tmr_q;
            end
        endcase
        tmr_d = tmr_d & top;
    end

    // timer register with coherent software access
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tmr_q <= RST_TMR;
        end else if (WR && ADDR == ADDR_TMR_HI) begin
            tmr_q <= {WDATA[7:0], lo_shadow_q};
        end else if (tick) begin
            tmr_q <= tmr_d;
        end
    end

    // shadow bytes: low written first, high read after low
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lo_shadow_q <= 8'h00;
            hi_shadow_q <= 8'h00;
        end else begin
            if (WR && ADDR == ADDR_TMR_LO) begin
                lo_shadow_q <= WDATA[7:0];
            end
            if (RD && ADDR == ADDR_TMR_LO) begin
                hi_shadow_q <= tmr_q[15:8];
            end
        end
    end

    // symmetric direction and alternating pair phase
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sym_up_q <= 1'b1;
            alt_q <= 1'b0;
        end else if (tick) begin
            if (mode == MODE_SYM && sym_up_q && tmr_q + 16'h0001 >= (rld_q & top)) begin
                sym_up_q <= 1'b0;
            end else if (mode == MODE_SYM && !sym_up_q && tmr_q == 16'h0000) begin
                sym_up_q <= 1'b1;
            end
            if (reload) begin
                alt_q <= ~alt_q;
            end
        end
    end

    // configuration registers
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_q <= RST_CFG;
            presc_rld_q <= RST_CFG;
            rld_q <= RST_CFG;
            capcfg_q <= RST_CFG;
            outcfg_q <= RST_CFG;
            ien_q <= RST_CFG;
        end else if (WR) begin
            case (ADDR)
                ADDR_CTRL: ctrl_q <= WDATA;
                ADDR_PRESC: presc_rld_q <= WDATA;
                ADDR_RLD_LO: rld_q[7:0] <= WDATA[7:0];
                ADDR_RLD_HI: rld_q[15:8] <= WDATA[7:0];
                ADDR_CAPCFG: capcfg_q <= WDATA;
                ADDR_OUTCFG: outcfg_q <= WDATA;
                ADDR_IEN: ien_q <= WDATA;
                default: ;
            endcase
        end
    end

    // compare channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            logic match, gate;
            assign match = tick && outcfg_q[gi] && (tmr_q == cmp_q[gi]);
            assign gate = !ctrl_q[CTRL_ALT_BIT] || mode != MODE_ASYM || (alt_q == 1'(gi % 2));
            assign set_ev[FLG_CMP_LSB + gi] = match;
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    cmp_q[gi] <= RST_TMR;
                end else if (WR && ADDR == ADDR_CMP_BASE + 4'(gi)) begin
                    cmp_q[gi] <= WDATA;
                end
            end
            // pin changes on a compare event, clears on asymmetric reload, and otherwise takes the halt level while output is disabled
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    pin_q[gi] <= 1'b0;
                end else if (match && gate) begin
                    if (mode == MODE_BASIC) begin
                        pin_q[gi] <= ~pin_q[gi];
                    end else if (mode == MODE_SYM) begin
                        pin_q[gi] <= sym_up_q;
                    end else begin
                        pin_q[gi] <= 1'b1;
                    end
                end else if (tick && reload && mode == MODE_ASYM) begin
                    pin_q[gi] <= 1'b0;
                end else if (!outcfg_q[8+gi]) begin
                    pin_q[gi] <= outcfg_q[12+gi] ^ outcfg_q[4+gi]; // halt level held
                end
            end
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    CMP_OUT[gi] <= 1'b0;
                    CMP_OE[gi] <= 1'b0;
                end else begin
                    CMP_OUT[gi] <= (pin_q[gi] && gate) ^ outcfg_q[4+gi];
                    CMP_OE[gi] <= outcfg_q[gi] && outcfg_q[8+gi];
                end
            end
        end
    endgenerate

    // capture inputs: sync, filter, edge, event count
    generate
        for (gi = 0; gi < NUM_CAP; gi++) begin : g_cap
            logic s1_q, s2_q, lvl_q;
            logic [2:0] hist_q;
            logic [3:0] ev_q;
            logic lvl_d, edge_ok;
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    hist_q <= 3'h0;
                end else begin
                    s1_q <= CAP_IN[gi];
                    s2_q <= s1_q;
                    hist_q <= {hist_q[1:0], s2_q};
                end
            end
            // filtered level needs four equal samples
            assign lvl_d = capcfg_q[2+gi] ?
                ((&{hist_q, s2_q}) ? 1'b1 : (~|{hist_q, s2_q}) ? 1'b0 : lvl_q) : s2_q;
            assign edge_ok = (lvl_d != lvl_q) && (lvl_d == !capcfg_q[gi]);
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    lvl_q <= 1'b0;
                    ev_q <= 4'h0;
                    cap_q[gi] <= RST_TMR;
                end else begin
                    lvl_q <= lvl_d;
                    if (edge_ok) begin
                        if (ev_q >= capcfg_q[4+4*gi +: 4]) begin
                            ev_q <= 4'h0;
                            cap_q[gi] <= tmr_q;
                        end else begin
                            ev_q <= ev_q + 4'h1;
                        end
                    end
                end
            end
            assign set_ev[FLG_CAP_LSB + gi] = edge_ok && (ev_q >= capcfg_q[4+4*gi +: 4]);
        end
    endgenerate

    assign set_ev[FLG_OVF] = tick && reload;

    // flags: write one to clear, a new event wins
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_q <= '0;
        end else if (WR && ADDR == ADDR_FLAGS) begin
            flags_q <= (flags_q & ~WDATA[NUM_IRQ-1:0]) | set_ev;
        end else begin
            flags_q <= flags_q | set_ev;
        end
    end
    assign IRQ = |(flags_q & ien_q[NUM_IRQ-1:0]);

    // read data one cycle after read strobe
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            case (ADDR)
                ADDR_CTRL: RDATA <= ctrl_q;
                ADDR_PRESC: RDATA <= presc_rld_q;
                ADDR_TMR_LO: RDATA <= {8'h00, tmr_q[7:0]};
                ADDR_TMR_HI: RDATA <= {8'h00, hi_shadow_q};
                ADDR_RLD_LO: RDATA <= {8'h00, rld_q[7:0]};
                ADDR_RLD_HI: RDATA <= {8'h00, rld_q[15:8]};
                ADDR_CAP0: RDATA <= cap_q[0];
                ADDR_CAP1: RDATA <= cap_q[1];
                ADDR_CAPCFG: RDATA <= capcfg_q;
                ADDR_OUTCFG: RDATA <= outcfg_q;
                ADDR_IEN: RDATA <= ien_q;
                ADDR_FLAGS: RDATA <= {9'h000, flags_q};
                default: RDATA <= cmp_q[ADDR[1:0] - 2'd2];
            endcase
        end
    end
endmodule : ccp_unit

/* File: hw/ccp_pkg.sv */
// package of constants for the capture/compare/pwm unit
// Summary of operation
// - 16-bit timer reloads programmed value on overflow
// - prescaler divides by any ratio 1..1024
// - prescaler is 10-bit counter reloading on overflow
// - unit clock: peripheral clock basic, pll in pwm
// - pll multiplies 0.5-1 MHz reference by 32
// - 4-bit divider scales peripheral clock to reference
// - basic mode direction bit, reversal takes effect immediately
// - coherent 16-bit timer access through shadow registers
// - each reload sets overflow flag, interrupt if enabled
// - optional 8-bit up/down counting width
// - four compare channels, enable and pin gating
// - timer equals compare sets match flag, interrupt
// - each compare output has selectable polarity
// - capture always on, copies timer to register
// - capture edge selectable rising or falling
// - filter needs four equal samples per edge
// - event counter delays capture by programmed events
// - seven interrupt sources share one request
// - asymmetric pwm always counts down
// - symmetric pwm alternates up and down counting
// - pwm pin set by compare, symmetric down-count compare clears it; asymmetric reload clears it, otherwise halt level while disabled
// - asymmetric alternating pairs A/B, C/D per cycle
// - pll reference is pclk divided by value plus one
package ccp_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PRESC = 4'h1;
    localparam logic [3:0] ADDR_TMR_LO = 4'h2;
    localparam logic [3:0] ADDR_TMR_HI = 4'h3;
    localparam logic [3:0] ADDR_RLD_LO = 4'h4;
    localparam logic [3:0] ADDR_RLD_HI = 4'h5;
    localparam logic [3:0] ADDR_CMP_BASE = 4'h6;
    localparam logic [3:0] ADDR_CAP0 = 4'hA;
    localparam logic [3:0] ADDR_CAP1 = 4'hB;
    localparam logic [3:0] ADDR_CAPCFG = 4'hC;
    localparam logic [3:0] ADDR_OUTCFG = 4'hD;
    localparam logic [3:0] ADDR_IEN = 4'hE;
    localparam logic [3:0] ADDR_FLAGS = 4'hF;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIR_BIT = 2;
    localparam int CTRL_W8_BIT = 3;
    localparam int CTRL_ALT_BIT = 4;
    localparam int CTRL_RUN_BIT = 5;
    localparam int CTRL_PLLDIV_LSB = 8;
    // flag register layout
    localparam int FLG_OVF = 0;
    localparam int FLG_CAP_LSB = 1;
    localparam int FLG_CMP_LSB = 3;
    localparam int NUM_IRQ = 7;
    localparam int NUM_CMP = 4;
    localparam int NUM_CAP = 2;
    localparam int FILT_SAMPLES = 4;
    localparam int PLL_MULT = 32;
    localparam logic [15:0] RST_CFG = 16'h0000;
    localparam logic [15:0] RST_TMR = 16'h0000;
    localparam logic [9:0] RST_PRESC = 10'h000;
    typedef enum logic [1:0] {MODE_BASIC, MODE_ASYM, MODE_SYM, MODE_RSVD} ccp_mode_e;
endpackage : ccp_pkg

/* File: tb/ccp_unit_props.sv */
// port-level assertions for the capture/compare/pwm unit
`timescale 1ns/10ps
module ccp_unit_props
    import ccp_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire logic [3:0] CMP_OE,
    input wire logic PLL_REF_EN,
    input wire logic IRQ
);
    logic [3:0] div_q;
    logic [3:0] gap_q;
    logic seen_q;
    logic [6:0] ien_q;
    logic [3:0] pin_q;
    wire logic ctl_wr = WR && ADDR == ADDR_CTRL;
    // shadows of written fields; gap counts clocks since the last reference pulse
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_q <= 4'h0;
            gap_q <= 4'h0;
            seen_q <= 1'b0;
            ien_q <= 7'h00;
            pin_q <= 4'h0;
        end else begin
            div_q <= ctl_wr ? WDATA[11:8] : div_q;
            ien_q <= (WR && ADDR == ADDR_IEN) ? WDATA[6:0] : ien_q;
            pin_q <= (WR && ADDR == ADDR_OUTCFG) ? WDATA[3:0] & WDATA[11:8] : pin_q;
            gap_q <= PLL_REF_EN ? 4'h0 : gap_q + 4'h1;
            seen_q <= !ctl_wr && (PLL_REF_EN || seen_q); // a new divider restarts the spacing
        end
    end
    default clocking dcb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence ctl_write_s;
        ctl_wr;
    endsequence
    sequence ref_soon_s;
        ##[1:18] PLL_REF_EN;
    endsequence
    a_ref_gap_exact: assert property (PLL_REF_EN && seen_q |-> gap_q == div_q)
        else $error("reference pulse spacing wrong");
    a_ref_none_missed: assert property (seen_q && !PLL_REF_EN |-> gap_q < div_q)
        else $error("reference pulse missing");
    a_ref_after_cfg: assert property (ctl_write_s |-> ref_soon_s)
        else $error("no reference pulse after divider write");
    a_reset_outputs_quiet: assert property ($rose(RESET_N) |-> CMP_OE == 4'h0 && !IRQ)
        else $error("outputs active after reset");
    a_rdata_hold: assert property (!RD |=> $stable(RDATA))
        else $error("read data changed without a read");
    a_irq_masked: assert property (ien_q == 7'h00 |-> !IRQ)
        else $error("interrupt with all sources masked");
    a_irq_held: assert property (IRQ && !(WR && ADDR >= ADDR_IEN) |=> IRQ)
        else $error("interrupt dropped without clear or mask");
    a_oe_gated: assert property ((CMP_OE & ~(pin_q | $past(pin_q))) == 4'h0)
        else $error("compare pin driven while not enabled");
endmodule : ccp_unit_props
bind ccp_unit ccp_unit_props u_props (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CMP_OE(CMP_OE),
    .PLL_REF_EN(PLL_REF_EN), .IRQ(IRQ));

/* File: tb/ccp_pins_model.sv */
// capture sources at the unit's input pins
`timescale 1ns/10ps
module ccp_pins_model (
    input wire logic CLK,
    output logic [1:0] CAP_IN
);
    initial CAP_IN = 2'b00;
    // set one source to a level just after an edge and hold it for some clocks
    task automatic drive(input int ch, input logic lvl, input int cycles);
        @(posedge CLK);
        CAP_IN[ch] <= lvl;
        repeat (cycles) @(posedge CLK);
    endtask : drive
endmodule : ccp_pins_model

/* File: tb/ccp_unit_test.sv */
// self-checking bench for the capture/compare/pwm unit
`timescale 1ns/10ps
module ccp_unit_test;
    import ccp_pkg::*;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic PLL_CLK_EN = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [15:0] RDATA;
    logic [1:0] CAP_IN;
    logic [3:0] CMP_OUT;
    logic [3:0] CMP_OE;
    logic PLL_REF_EN;
    logic IRQ;
    logic rnd_en = 1'b0;
    logic pll_on = 1'b0;
    logic [15:0] val;
    logic [15:0] lo;
    int seed = 32'h4e66_d35a;
    int bad_count = 0;
    int tests_run = 0;
    int model[16];
    int pulses;
    int tri_v;
    int tri_up;
    always #5 CLK = ~CLK;
    ccp_unit u_ccp_unit (.CLK(CLK), .RESET_N(RESET_N), .PLL_CLK_EN(PLL_CLK_EN), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CAP_IN(CAP_IN), .CMP_OUT(CMP_OUT),
        .CMP_OE(CMP_OE), .PLL_REF_EN(PLL_REF_EN), .IRQ(IRQ));
    ccp_pins_model u_pins (.CLK(CLK), .CAP_IN(CAP_IN));
    // random pll output pulses while enabled
    always @(posedge CLK) PLL_CLK_EN <= pll_on || (rnd_en && ($random(seed) % 2 != 0));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        model[a] = d;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 val = RDATA;
    endtask : rd
    task automatic rdchk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        rd(a);
        check($sformatf("reg %h", a), val & m, e);
    endtask : rdchk
    task automatic tmr_wr(input logic [15:0] v);
        wr(ADDR_TMR_LO, {8'h00, v[7:0]});
        wr(ADDR_TMR_HI, {8'h00, v[15:8]});
    endtask : tmr_wr
    task automatic tmr_rd();
        rd(ADDR_TMR_LO);
        lo = val;
        rd(ADDR_TMR_HI);
        val = {val[7:0], lo[7:0]};
    endtask : tmr_rd
    task automatic idle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : idle
    // run the prescaler up to its terminal count so the programmed ratio applies at once
    task automatic presc_sync();
        wr(ADDR_CTRL, 16'h0020);
        idle(1030);
        wr(ADDR_CTRL, 16'h0000);
    endtask : presc_sync
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        static logic [15:0] ctl[5] = '{16'h0020, 16'h0024, 16'h0021, 16'h0021, 16'h0028};
        static logic [1:0] dir[5] = '{2'b10, 2'b01, 2'b00, 2'b01, 2'b01};
        repeat (12) @(posedge CLK);
        RESET_N <= 1'b1;
        #1;
        check("irq", {15'h0, IRQ}, 16'h0000);
        rdchk(ADDR_CTRL, RST_CFG, 16'hFFFF);
        rdchk(ADDR_FLAGS, 16'h0000, 16'h007F);
        for (int i = 0; i < NUM_CMP; i++) begin
            wr(ADDR_CMP_BASE + 4'(i), 16'($random(seed)));
            rdchk(ADDR_CMP_BASE + 4'(i), 16'(model[ADDR_CMP_BASE + i]), 16'hFFFF);
        end
        wr(ADDR_PRESC, 16'h03FF);
        rdchk(ADDR_PRESC, 16'h03FF, 16'h03FF);
        presc_sync();
        wr(ADDR_RLD_LO, 16'h00F0);
        wr(ADDR_RLD_HI, 16'h00FF);
        tmr_wr(16'hFFFA);
        wr(ADDR_IEN, 16'h0001);
        wr(ADDR_CTRL, 16'h0020);
        idle(12);
        wr(ADDR_CTRL, 16'h0000);
        check("irq", {15'h0, IRQ}, 16'h0001);
        tmr_rd();
        check("reload", {15'h0, val >= 16'hFFF0}, 16'h0001);
        wr(ADDR_IEN, 16'h0000);
        check("irq", {15'h0, IRQ}, 16'h0000);
        wr(ADDR_FLAGS, 16'h007F);
        rdchk(ADDR_FLAGS, 16'h0000, 16'h007F);
        // direction, asymmetric down count, pll clocking and 8-bit width
        for (int k = 0; k < 5; k++) begin
            tmr_wr(k == 4 ? 16'h00FA : 16'h0100);
            rnd_en = k == 3;
            wr(ADDR_CTRL, ctl[k]);
            idle(20);
            wr(ADDR_CTRL, 16'h0000);
            tmr_rd();
            check("dir", {14'h0, val > 16'h0100, val < 16'h0100}, {14'h0, dir[k]});
        end
        // prescaler ratios 4 and 1024
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_PRESC, k == 0 ? 16'h03FC : 16'h0000);
            tmr_wr(16'h0000);
            wr(ADDR_CTRL, 16'h0020);
            idle(k == 0 ? 40 : 2100);
            wr(ADDR_CTRL, 16'h0000);
            tmr_rd();
            check("ticks", {15'h0, val >= (k == 0 ? 9 : 1) && val <= (k == 0 ? 11 : 3)}, 16'h0001);
        end
        wr(ADDR_PRESC, 16'h03FF);
        presc_sync();
        wr(ADDR_OUTCFG, 16'h0F0F);
        idle(2);
        check("oe", {12'h0, CMP_OE}, 16'h000F);
        wr(ADDR_CMP_BASE, 16'h0105);
        for (int i = 1; i < NUM_CMP; i++) wr(ADDR_CMP_BASE + 4'(i), 16'h9000);
        tmr_wr(16'h0100);
        wr(ADDR_FLAGS, 16'h007F);
        wr(ADDR_CTRL, 16'h0020);
        idle(15);
        wr(ADDR_CTRL, 16'h0000);
        rdchk(ADDR_FLAGS, 16'h0008, 16'h0078);
        check("out", {12'h0, CMP_OUT}, 16'h0001);
        wr(ADDR_OUTCFG, 16'h0FFF);
        idle(2);
        check("pol", {12'h0, CMP_OUT}, 16'h000E);
        wr(ADDR_OUTCFG, 16'h000F);
        idle(2);
        check("oe", {12'h0, CMP_OE}, 16'h0000);
        check("out", {12'h0, CMP_OUT}, 16'h0000);
        // capture edges, filter and event count
        tmr_wr(16'h1234);
        wr(ADDR_CAPCFG, 16'h0002);
        wr(ADDR_IEN, 16'h0006);
        wr(ADDR_FLAGS, 16'h007F);
        u_pins.drive(0, 1'b1, 6);
        u_pins.drive(1, 1'b1, 6);
        rdchk(ADDR_CAP0, 16'h1234, 16'hFFFF);
        rdchk(ADDR_FLAGS, 16'h0002, 16'h0006);
        check("irq", {15'h0, IRQ}, 16'h0001);
        tmr_wr(16'h5678);
        u_pins.drive(1, 1'b0, 6);
        rdchk(ADDR_CAP1, 16'h5678, 16'hFFFF);
        wr(ADDR_CAPCFG, 16'h0006);
        wr(ADDR_FLAGS, 16'h007F);
        u_pins.drive(0, 1'b0, 1);
        u_pins.drive(0, 1'b1, 8);
        rdchk(ADDR_FLAGS, 16'h0000, 16'h0002);
        u_pins.drive(0, 1'b0, 8);
        u_pins.drive(0, 1'b1, 8);
        rdchk(ADDR_FLAGS, 16'h0002, 16'h0002);
        wr(ADDR_CAPCFG, 16'h0020);
        wr(ADDR_FLAGS, 16'h007F);
        for (int e = 0; e < 3; e++) begin
            u_pins.drive(0, 1'b0, 6);
            u_pins.drive(0, 1'b1, 6);
            if (e == 0) rdchk(ADDR_FLAGS, 16'h0000, 16'h0002);
        end
        rdchk(ADDR_FLAGS, 16'h0002, 16'h0002);
        // symmetric triangle up to reload 8 and back down to 4, on a steady pll clock
        pll_on = 1'b1;
        wr(ADDR_RLD_LO, 16'h0008);
        wr(ADDR_RLD_HI, 16'h0000);
        wr(ADDR_CMP_BASE, 16'h0004);
        wr(ADDR_OUTCFG, 16'h0101);
        tmr_wr(16'h0000);
        wr(ADDR_CTRL, 16'h0022);
        idle(11);
        wr(ADDR_CTRL, 16'h0000);
        tri_v = 0;
        tri_up = 1;
        repeat (12) begin
            tri_v = (tri_up != 0) ? tri_v + 1 : tri_v - 1;
            if (tri_v == 8) tri_up = 0;
            if (tri_v == 0) tri_up = 1;
        end
        tmr_rd();
        check("sym", val, 16'(tri_v));
        check("pwm", {12'h0, CMP_OUT}, 16'h0001);
        // alternating pair: only one of A and B may pass a common match
        wr(ADDR_OUTCFG, 16'h0303);
        wr(ADDR_CMP_BASE + 4'h1, 16'h0001);
        wr(ADDR_CMP_BASE, 16'h0001);
        tmr_wr(16'h0002);
        wr(ADDR_CTRL, 16'h0031);
        idle(1);
        wr(ADDR_CTRL, 16'h0011);
        idle(2);
        check("alt", {15'h0, ^CMP_OUT[1:0]}, 16'h0001);
        pll_on = 1'b0;
        // reference pulses per 48 clocks for divider values 0, 3 and 15
        for (int n = 0; n < 16; n += (n == 0) ? 3 : 12) begin
            wr(ADDR_CTRL, 16'(n << CTRL_PLLDIV_LSB));
            idle(20);
            pulses = 0;
            repeat (48) begin
                @(posedge CLK);
                #1 pulses += int'(PLL_REF_EN === 1'b1);
            end
            check("refs", 16'(pulses), 16'(48 / (n + 1)));
        end
        complete_run();
    end
    // watchdog against a hang
    initial begin
        #200000;
        bad_count++;
        complete_run();
    end
endmodule : ccp_unit_test
